// file: hw/pin_sync.sv
// Two-flop synchroniser for the continuously watched pin groups
`timescale 1ns/1ns
module pin_sync (
   input wire logic ref_clk,
   input wire logic rstSync_n,
   sync_bus_if.sync pins
);
   // All synchroniser stages in one struct
   typedef struct packed {
      logic [7:0] q1;
      logic [7:0] q2;
      logic [7:0] m1;
      logic [7:0] m2;
      logic [15:0] b1;
      logic [15:0] b2;
   } sync_state_t;

   sync_state_t state_ff;
   sync_state_t nxt_state;

   ////////////////////////////////////////////////////////////////////////
   // Next state: first stage feeds only the second
   always_comb begin
      nxt_state = state_ff;
      nxt_state.q1 = pins.quasiRaw;
      nxt_state.q2 = state_ff.q1;
      nxt_state.m1 = pins.mixedRaw;
      nxt_state.m2 = state_ff.m1;
      nxt_state.b1 = pins.busRaw;
      nxt_state.b2 = state_ff.b1;
   end

   // Register stage, constants only under reset
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pins.quasiSync = state_ff.q2;
   assign pins.mixedSync = state_ff.m2;
   assign pins.busSync = state_ff.b2;
endmodule

// file: hw/port_io_and_pin_sharing.sv
// Parallel port block: five byte ports, pin sharing and register access
`timescale 1ns/1ns
// What this block does
// - Five eight-bit ports of mixed kinds
// - Analog-shared input port read at 0x0E
// - Quasi port read and written at 0x0F
// - Quasi port top bits carry bus hold
// - Mixed port read and written at 0x10
// - Ports hidden while window 15 selected
// - Open-drain bus ports at 0x1FFE
// - Line 0 output, serial transmit option
// - Line 1 input, serial receive data
// - Line 2 input, external interrupt option
// - Line 3 input, timer clock option
// - Line 4 input, timer reset option
// - Line 5 output, pulse-width output option
// - Line 6 quasi, timer direction option
// - Line 7 quasi, always timer capture
// - Input-only lines have no drivers
// - Analog lines stay usable as digital
// - Analog port sampled only on reads
// - Quasi write latches, read gives pin
module port_io_and_pin_sharing (
   input wire logic ref_clk,
   input wire logic arst_n,
   // CPU special-function bus
   input wire logic [12:0] sfrAddr,
   input wire logic sfrRead,
   input wire logic sfrWrite,
   input wire logic [15:0] sfrWdata,
   // Window 15 hides every port location
   input wire logic [3:0] windowSelect,
   input wire logic onChipProgram,
   // Read answer comes one edge after the read strobe
   output logic [15:0] sfrRdata,
   output logic sfrRvalid,
   // Control register bits from the peripherals
   input wire logic [7:0] io_control_zero,
   input wire logic [7:0] io_control_one,
   input wire logic [7:0] io_control_two,
   input wire logic [7:0] serial_control_register,
   // Alternate function sources
   input wire logic serialTxData,
   input wire logic pwmOutput,
   // Levels from the bus controller, same clock
   input wire logic busHoldEnable,
   input wire logic bus_hold_acknowledge,
   input wire logic bus_request_output,
   input wire logic [15:0] busAdOut,
   input wire logic busAdDrive,
   // Alternate function results
   output logic serialRxData,
   output logic external_interrupt_input,
   output logic second_timer_clock_input,
   output logic second_timer_reset_input,
   output logic secondTimerUpDown,
   output logic secondTimerCapture,
   output logic busHoldRequest_n,
   output logic [15:0] busAdIn,
   output logic [7:0] analogDigitalView,
   // Pins
   // Pin levels are asynchronous to the clock
   input wire logic [7:0] analogPortPin,
   input wire logic [7:0] quasiPortIn,
   output logic [7:0] quasiPortOut,
   output logic [7:0] quasiPortOe_n,
   input wire logic [7:0] mixedPortIn,
   output logic [7:0] mixedPortOut,
   output logic [7:0] mixedPortOe_n,
   input wire logic [15:0] busPortIn,
   output logic [15:0] busPortOut,
   output logic [15:0] busPortOe_n
);
   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   // Assertion is immediate; release waits two edges so that no flop
   // leaves reset on an edge of its own choosing
   // First stage, may go metastable on release
   logic rstMeta_ff;
   // Clean copy used by the rest of the block
   logic rstSync_ff;

   // Asynchronous assert, synchronous release
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronised pin levels
   // Analog pins are left out: they are sampled only on a read
   sync_bus_if pins ();
   assign pins.quasiRaw = quasiPortIn;
   assign pins.mixedRaw = mixedPortIn;
   assign pins.busRaw = busPortIn;

   // Two flops per line, so pin reads lag the pins by two edges
   pin_sync u_sync (
      .ref_clk(ref_clk),
      .rstSync_n(rstSync_ff),
      .pins(pins)
   );

   ////////////////////////////////////////////////////////////////////////
   // Whole block state
   // One struct so every register shares one reset and one update
   typedef struct packed {
      // Output latch of the quasi port
      logic [7:0] quasiLatch;
      // Output latch of the mixed port; only lines 0, 5, 6, 7 use it
      logic [7:0] mixedLatch;
      // Latches of both open-drain ports, low byte first port
      logic [15:0] busLatch;
      // Analog pins as seen at the last read of their location
      logic [7:0] analogMeta;
      // Read data, held until the next read
      logic [15:0] rdata;
      // One-cycle read answer
      logic rvalid;
   } port_state_t;

   // Registered state
   port_state_t state_ff;
   // Value the state takes at the next edge
   port_state_t nxt_state;

   // Address match, gated off in the hidden window
   // Shared by every location so no decode can miss the window test
   function automatic logic hit(input logic [12:0] addr, input logic [12:0] want,
                                input logic [3:0] win);
      hit = (addr == want) && (win != port_io_pkg::HIDDEN_WINDOW);
   endfunction

   // Quasi-bidirectional drive: strong low only, weak high by pullup
   // A one releases the pin to the pullup, a zero pulls it low
   function automatic logic [7:0] quasiOe(input logic [7:0] level);
      quasiOe = level;
   endfunction

   // Location decodes, all gated by the window
   logic hitAnalog;
   logic hitQuasi;
   logic hitMixed;
   logic hitBus;
   // Drive patterns of the quasi and mixed pins
   logic [7:0] quasiDrive;
   logic [7:0] mixedDrive;

   assign hitAnalog = hit(sfrAddr, port_io_pkg::ANALOG_PORT_ADDR, windowSelect);
   assign hitQuasi = hit(sfrAddr, port_io_pkg::QUASI_PORT_ADDR, windowSelect);
   assign hitMixed = hit(sfrAddr, port_io_pkg::MIXED_PORT_ADDR, windowSelect);
   // Parts without on-chip program memory keep these pins as the bus
   // on-chip program parts only
   assign hitBus = hit(sfrAddr, port_io_pkg::BUS_PORTS_ADDR, windowSelect) && onChipProgram;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for latches and read data
   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = 1'b0;
      // Writes land in latches; analog location has none
      // Hidden window and unmapped locations fail every decode
      if (sfrWrite) begin
         if (hitQuasi) begin
            nxt_state.quasiLatch = sfrWdata[7:0];
         end
         if (hitMixed) begin
            nxt_state.mixedLatch = sfrWdata[7:0];
         end
         if (hitBus) begin
            nxt_state.busLatch = sfrWdata;
         end
      end
      // Analog port is sampled only on its own read
      // Read and write in one cycle: the read sees pins, not the new latch
      if (sfrRead) begin
         // Every read answers, so the bus never waits
         nxt_state.rvalid = 1'b1;
         // Bytes ride in the low half, upper half zero
         nxt_state.rdata = 16'h0000;
         if (hitAnalog) begin
            nxt_state.analogMeta = analogPortPin;
            nxt_state.rdata = {port_io_pkg::BYTE_ZERO, analogPortPin};
         end else if (hitQuasi) begin
            nxt_state.rdata = {port_io_pkg::BYTE_ZERO, pins.quasiSync};
         end else if (hitMixed) begin
            nxt_state.rdata = {port_io_pkg::BYTE_ZERO, pins.mixedSync};
         end else if (hitBus) begin
            nxt_state.rdata = pins.busSync;
         end else begin
            // Unmapped or hidden location reads zero
            nxt_state.rdata = 16'h0000;
         end
      end
   end

   // State register, reset to all latches high
   // Latches high leave every quasi and open-drain line released
   always_ff @(posedge ref_clk or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         state_ff.quasiLatch <= port_io_pkg::QUASI_RESET;
         state_ff.mixedLatch <= port_io_pkg::QUASI_RESET;
         state_ff.busLatch <= port_io_pkg::BUS_PORTS_RESET;
         state_ff.analogMeta <= port_io_pkg::BYTE_ZERO;
         state_ff.rdata <= 16'h0000;
         state_ff.rvalid <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Read answer straight from flops
   assign sfrRdata = state_ff.rdata;
   assign sfrRvalid = state_ff.rvalid;
   assign analogDigitalView = state_ff.analogMeta;

   ////////////////////////////////////////////////////////////////////////
   // Quasi port drive with bus hold alternate functions
   always_comb begin
      quasiDrive = state_ff.quasiLatch;
      // bus hold lines act as quasi lines; acknowledge and request output pull low only
      if (busHoldEnable) begin
         // Hold request is an input, so its line stays released
         quasiDrive[port_io_pkg::HOLD_LINE] = 1'b1;
         quasiDrive[port_io_pkg::HOLD_ACK_LINE] = bus_hold_acknowledge;
         quasiDrive[port_io_pkg::BUS_REQ_LINE] = bus_request_output;
      end
   end

   // quasi port and hold request wired out
   // Quasi pins never drive high; a released line rises on the pullup
   assign quasiPortOut = 8'h00;
   assign quasiPortOe_n = quasiOe(quasiDrive);
   assign busHoldRequest_n = busHoldEnable ? pins.quasiSync[port_io_pkg::HOLD_LINE] : 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Mixed port: outputs, inputs and quasi lines
   always_comb begin
      // Lines 1 to 4 are inputs; their drive value is never used
      mixedDrive = 8'hFF;
      mixedDrive[port_io_pkg::LINE_TXD] =
         io_control_one[port_io_pkg::CTRL_ONE_TXD_BIT] ? serialTxData :
         state_ff.mixedLatch[port_io_pkg::LINE_TXD];
      mixedDrive[port_io_pkg::LINE_PWM] =
         io_control_one[port_io_pkg::CTRL_ONE_PWM_BIT] ? pwmOutput :
         state_ff.mixedLatch[port_io_pkg::LINE_PWM];
      mixedDrive[port_io_pkg::LINE_UPDN] = state_ff.mixedLatch[port_io_pkg::LINE_UPDN];
      mixedDrive[port_io_pkg::LINE_CAPT] = state_ff.mixedLatch[port_io_pkg::LINE_CAPT];
   end

   // Outputs drive both levels; quasi lines drive low only
   assign mixedPortOut = mixedDrive;
   // input lines never driven
   // Lines 6 and 7 release on a one and pull low on a zero
   assign mixedPortOe_n = {mixedDrive[7:6], 1'b0, 3'b111, 1'b1, 1'b0};

   // Alternate inputs read the synchronised pins; a disabled one rests idle
   // receive data under serial control
   assign serialRxData = serial_control_register[port_io_pkg::SERIAL_CTRL_RXD_BIT] ?
                         pins.mixedSync[port_io_pkg::LINE_RXD] : 1'b1;
   assign external_interrupt_input = io_control_one[port_io_pkg::CTRL_ONE_EXT_IRQ_BIT] &
                                     pins.mixedSync[port_io_pkg::LINE_EXT_IRQ];
   assign second_timer_clock_input = io_control_zero[port_io_pkg::CTRL_ZERO_TMR_CLK_BIT] &
                                     pins.mixedSync[port_io_pkg::LINE_TMR_CLK];
   assign second_timer_reset_input = io_control_zero[port_io_pkg::CTRL_ZERO_TMR_RST_BIT] &
                                     pins.mixedSync[port_io_pkg::LINE_TMR_RST];
   assign secondTimerUpDown = io_control_two[port_io_pkg::CTRL_TWO_UPDN_BIT] &
                              pins.mixedSync[port_io_pkg::LINE_UPDN];
   // Capture has no enable of its own; the timer must mask it if unwanted
   // capture always routed
   assign secondTimerCapture = pins.mixedSync[port_io_pkg::LINE_CAPT];

   ////////////////////////////////////////////////////////////////////////
   // Open-drain bus ports; bus cycles override the latch
   // Latch ones release the pins; write ones before the bus takes them
   assign busPortOut = busAdDrive ? busAdOut : 16'h0000;
   // Bus cycles drive both levels
   assign busPortOe_n = busAdDrive ? 16'h0000 : state_ff.busLatch;
   // Bus input view is synchronised like the other pins
   assign busAdIn = pins.busSync;
endmodule

// file: hw/port_io_pkg.sv
// Package holding offsets, field positions and reset values of the port block
package port_io_pkg;
   // Special-function addresses of the port locations
   localparam logic [12:0] ANALOG_PORT_ADDR = 13'h000E;
   localparam logic [12:0] QUASI_PORT_ADDR = 13'h000F;
   localparam logic [12:0] MIXED_PORT_ADDR = 13'h0010;
   localparam logic [12:0] BUS_PORTS_ADDR = 13'h1FFE;
   // Register window that hides the ports
   localparam logic [3:0] HIDDEN_WINDOW = 4'hF;
   // Control bit positions
   localparam int CTRL_ONE_TXD_BIT = 5;
   localparam int SERIAL_CTRL_RXD_BIT = 3;
   localparam int CTRL_ONE_EXT_IRQ_BIT = 1;
   localparam int CTRL_ZERO_TMR_CLK_BIT = 7;
   localparam int CTRL_ZERO_TMR_RST_BIT = 5;
   localparam int CTRL_ONE_PWM_BIT = 0;
   localparam int CTRL_TWO_UPDN_BIT = 1;
   // Mixed port line positions
   localparam int LINE_TXD = 0;
   localparam int LINE_RXD = 1;
   localparam int LINE_EXT_IRQ = 2;
   localparam int LINE_TMR_CLK = 3;
   localparam int LINE_TMR_RST = 4;
   localparam int LINE_PWM = 5;
   localparam int LINE_UPDN = 6;
   localparam int LINE_CAPT = 7;
   // Latch reset values: ones so quasi lines float high
   localparam logic [7:0] QUASI_RESET = 8'hFF;
   localparam logic [15:0] BUS_PORTS_RESET = 16'hFFFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Bus hold control lines within the quasi port
   localparam int HOLD_LINE = 5;
   localparam int HOLD_ACK_LINE = 6;
   localparam int BUS_REQ_LINE = 7;
endpackage

// file: hw/sync_bus_if.sv
// Interface carrying raw and synchronised pin levels between modules
`timescale 1ns/1ns
interface sync_bus_if;
   logic [7:0] quasiRaw;
   logic [7:0] mixedRaw;
   logic [15:0] busRaw;
   logic [7:0] quasiSync;
   logic [7:0] mixedSync;
   logic [15:0] busSync;
   modport core (output quasiRaw, output mixedRaw, output busRaw,
                 input quasiSync, input mixedSync, input busSync);
   modport sync (input quasiRaw, input mixedRaw, input busRaw,
                 output quasiSync, output mixedSync, output busSync);
endinterface

// file: tb/pin_world.sv
// Model of the pins, switches and devices outside the port block
`timescale 1ns/1ns
module pin_world (
   input wire logic [7:0] quasiPortOut,
   input wire logic [7:0] quasiPortOe_n,
   input wire logic [7:0] quasiLow,
   output logic [7:0] quasiPortIn,
   input wire logic [7:0] mixedPortOut,
   input wire logic [7:0] mixedPortOe_n,
   input wire logic [7:0] mixedLow,
   output logic [7:0] mixedPortIn,
   input wire logic [15:0] busPortOut,
   input wire logic [15:0] busPortOe_n,
   input wire logic [15:0] busLow,
   output logic [15:0] busPortIn,
   input wire logic [7:0] analogLevel,
   output logic [7:0] analogPortPin
);
   // Released line rests high on the pullup; outside pulls it low
   assign quasiPortIn = (quasiPortOe_n | quasiPortOut) & ~quasiLow;
   assign mixedPortIn = (mixedPortOe_n | mixedPortOut) & ~mixedLow;
   assign busPortIn = (busPortOe_n | busPortOut) & ~busLow;
   // steady level, changed by the bench well before reads
   assign analogPortPin = analogLevel;
endmodule

// file: tb/port_io_and_pin_sharing_tb.sv
// Self-checking bench of the port block
`timescale 1ns/1ns
module port_io_and_pin_sharing_tb;
   logic ref_clk = 1'b0, arst_n = 1'b0, sfrRead = 1'b0, sfrWrite = 1'b0, onChipProgram = 1'b0;
   logic [12:0] sfrAddr = 13'h0000;
   logic [3:0] windowSelect = 4'h0;
   logic [15:0] sfrWdata = 16'h0000, busAdOut = 16'h0000, busLow = 16'h0000;
   logic [15:0] sfrRdata, busAdIn, busPortIn, busPortOut, busPortOe_n;
   logic [7:0] io_control_zero = 8'h00, io_control_one = 8'h00, io_control_two = 8'h00;
   logic [7:0] serial_control_register = 8'h00, quasiLow = 8'h00, mixedLow = 8'h00;
   logic [7:0] analogLevel = 8'h00, analogPortPin, quasiPortIn, quasiPortOut, quasiPortOe_n;
   logic [7:0] mixedPortIn, mixedPortOut, mixedPortOe_n, analogDigitalView;
   logic serialTxData = 1'b0, pwmOutput = 1'b0, busHoldEnable = 1'b0, busAdDrive = 1'b0;
   logic bus_hold_acknowledge = 1'b0, bus_request_output = 1'b0;
   logic sfrRvalid, serialRxData, external_interrupt_input, second_timer_clock_input;
   logic second_timer_reset_input, secondTimerUpDown, secondTimerCapture, busHoldRequest_n;
   int n_errors = 0, num_checks = 0, cycles = 0;
   port_io_and_pin_sharing dut (.*);
   pin_world world (.*);
   always #20 ref_clk = ~ref_clk;
   //////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Inputs move 1 ns after the edge, never on it
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [12:0] a, input logic [15:0] d);
      sfrAddr = a;
      sfrWdata = d;
      sfrWrite = 1'b1;
      tick(1);
      sfrWrite = 1'b0;
      // Idle edge keeps back-to-back strobes apart
      tick(1);
   endtask
   // Valid and data stand just after the edge that samples the read
   task automatic rd(input logic [12:0] a, input logic [15:0] exp);
      sfrAddr = a;
      sfrRead = 1'b1;
      tick(1);
      sfrRead = 1'b0;
      chk({15'h0000, sfrRvalid}, 16'h0001);
      chk(sfrRdata, exp);
      // Idle edge keeps back-to-back strobes apart
      tick(1);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   task automatic t_analog;
      analogLevel = 8'hA5;
      tick(2);
      rd(13'h000E, 16'h00A5);
      wr(13'h000E, 16'h003C);
      analogLevel = 8'h5A;
      tick(2);
      chk({8'h00, analogDigitalView}, 16'h00A5);
      rd(13'h000E, 16'h005A);
      chk({8'h00, analogDigitalView}, 16'h005A);
   endtask
   task automatic t_quasi;
      wr(13'h000F, 16'h005A);
      chk({8'h00, quasiPortOe_n}, 16'h005A);
      quasiLow = 8'h02;
      tick(3);
      rd(13'h000F, 16'h0058);
      quasiLow = 8'h00;
      windowSelect = 4'hF;
      wr(13'h000F, 16'h00FF);
      rd(13'h000F, 16'h0000);
      windowSelect = 4'h0;
      chk({8'h00, quasiPortOe_n}, 16'h005A);
   endtask
   task automatic t_mixed;
      io_control_one = 8'h23;
      io_control_zero = 8'hA0;
      io_control_two = 8'h02;
      serial_control_register = 8'h08;
      pwmOutput = 1'b1;
      mixedLow = 8'h14;
      wr(13'h0010, 16'h001F);
      tick(3);
      chk({14'h0000, mixedPortOut[5], mixedPortOut[0]}, 16'h0002);
      rd(13'h0010, 16'h002A);
      chk({10'h000, serialRxData, external_interrupt_input, second_timer_clock_input,
           second_timer_reset_input, secondTimerUpDown, secondTimerCapture}, 16'h0028);
      wr(13'h0010, 16'h00FF);
      mixedLow = 8'h0A;
      tick(3);
      chk({10'h000, serialRxData, external_interrupt_input, second_timer_clock_input,
           second_timer_reset_input, secondTimerUpDown, secondTimerCapture}, 16'h0017);
   endtask
   task automatic t_bus;
      onChipProgram = 1'b1;
      wr(13'h1FFE, 16'hA55A);
      chk(busPortOe_n, 16'hA55A);
      busLow = 16'h0002;
      tick(3);
      rd(13'h1FFE, 16'hA558);
      onChipProgram = 1'b0;
      rd(13'h1FFE, 16'h0000);
      busLow = 16'h0000;
      busAdOut = 16'h1234;
      busAdDrive = 1'b1;
      tick(3);
      chk(busAdIn, 16'h1234);
      busAdDrive = 1'b0;
   endtask
   task automatic t_hold;
      wr(13'h000F, 16'h00FF);
      busHoldEnable = 1'b1;
      bus_request_output = 1'b1;
      quasiLow = 8'h20;
      tick(3);
      chk({13'h0000, busHoldRequest_n, quasiPortOe_n[6], quasiPortOe_n[7]}, 16'h0001);
   endtask
   // Hang guard well above the 55 or so cycles used
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         $display("mismatch at %0t: timeout", $time);
         conclude();
      end
   end
   initial begin
      tick(2);
      arst_n = 1'b1;
      tick(3);
      chk({8'h00, quasiPortOe_n}, 16'h00FF);
      chk(busPortOe_n, 16'hFFFF);
      t_analog();
      t_quasi();
      t_mixed();
      t_bus();
      t_hold();
      conclude();
   end
endmodule

// file: tb/port_io_props.sv
// Checker of register timing and pin sharing of the port block
`timescale 1ns/1ns
module port_io_props (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [12:0] sfrAddr,
   input wire logic sfrRead,
   input wire logic sfrWrite,
   input wire logic [15:0] sfrWdata,
   input wire logic [3:0] windowSelect,
   input wire logic busHoldEnable,
   input wire logic [7:0] io_control_one,
   input wire logic [7:0] io_control_zero,
   input wire logic second_timer_reset_input,
   input wire logic [15:0] sfrRdata,
   input wire logic sfrRvalid,
   input wire logic external_interrupt_input,
   input wire logic secondTimerCapture,
   input wire logic [7:0] analogDigitalView,
   input wire logic [7:0] analogPortPin,
   input wire logic [7:0] mixedPortIn,
   input wire logic [7:0] mixedPortOe_n,
   input wire logic [7:0] quasiPortOe_n
);
   // Cycles since release; sync chain needs a few to fill
   logic [2:0] warm_ff;
   // Ports visible outside the hidden window
   wire open = windowSelect != 4'hF;
   wire anaRd = sfrRead && sfrAddr == 13'h000E && open;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   //////////////////////////////////////////////////////////////////
   // Saturating warm-up count
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         warm_ff <= 3'h0;
      else if (warm_ff != 3'h7)
         warm_ff <= warm_ff + 3'h1;
   end
   chk_read_answer: assert property (sfrRead |=> sfrRvalid)
      else $error("read without valid");
   chk_valid_cause: assert property (sfrRvalid |-> $past(sfrRead))
      else $error("valid without read");
   chk_hidden_zero: assert property (sfrRead && !open |=> sfrRdata == 16'h0000)
      else $error("hidden window read not zero");
   chk_analog_sample: assert property (anaRd |=>
      sfrRdata == {8'h00, $past(analogPortPin)} && analogDigitalView == $past(analogPortPin))
      else $error("analog read wrong");
   chk_analog_hold: assert property (!anaRd |=> $stable(analogDigitalView))
      else $error("analog view moved without read");
   chk_quasi_latch: assert property (sfrWrite && sfrAddr == 13'h000F && open
      && !busHoldEnable |=> quasiPortOe_n[4:0] == $past(sfrWdata[4:0]))
      else $error("quasi latch not written");
   chk_input_undriven: assert property (mixedPortOe_n[4:1] == 4'hF
      && mixedPortOe_n[0] == 1'b0 && mixedPortOe_n[5] == 1'b0)
      else $error("mixed drive enables wrong");
   chk_capture_line: assert property (warm_ff == 3'h7 |->
      secondTimerCapture == $past(mixedPortIn[7], 2))
      else $error("capture not following line 7");
   chk_external_interrupt_input_gate: assert property (warm_ff == 3'h7 |->
      external_interrupt_input == (io_control_one[1] & $past(mixedPortIn[2], 2)))
      else $error("interrupt gating wrong");
   chk_reset_gate: assert property (warm_ff == 3'h7 |->
      second_timer_reset_input == (io_control_zero[5] & $past(mixedPortIn[4], 2)))
      else $error("timer reset gating wrong");
   cover property (anaRd);
   cover property (sfrWrite && !open);
   cover property (sfrRead && sfrAddr == 13'h1FFE);
endmodule
bind port_io_and_pin_sharing port_io_props chk (.*);
